// File: design/usb_rx_fifo_flag_status.sv
/*
  receive fifo flag register, endpoint indexed, with a small
  register port, a read-complete strobe and an interrupt.
  assumes usb side pulses and sof are synchronous to clk and
  that endpoint_select is held by the register that owns it.
*/
`timescale 1ns/100ps
`default_nettype none
module usb_rx_fifo_flag_status
    import usb_rx_flag_pkg::*;
#(
    parameter int N_EP = usb_rx_flag_pkg::NUM_EP,
    parameter int SEL_W = usb_rx_flag_pkg::EP_W
) (
    // clock, reset, freeze
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // register port
    input wire logic [usb_rx_flag_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [usb_rx_flag_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [usb_rx_flag_pkg::DATA_W-1:0] reg_rdata,
    // endpoint select from its own register
    input wire logic [SEL_W-1:0] endpoint_select,
    // usb function interface side
    input wire logic [SEL_W-1:0] usb_ep,
    input wire logic rx_byte_count_wr,
    input wire logic advance_write_marker,
    input wire logic usb_sof,
    // interrupt
    output logic irq
);
    import usb_rx_flag_pkg::*;

    pkt_idx_t ep_idx [N_EP]; // visible index per endpoint
    logic [N_EP-1:0] ep_pkt_evt; // packets became visible
    pkt_idx_t sel_idx; // index of selected endpoint
    logic sel_empty; // live empty of selected endpoint
    logic rdc_pulse; // firmware read-complete strobe
    logic usb_inc; // usb side added a packet
    logic ctrl_dual_ff; // dual packet mode
    logic nxt_ctrl_dual;
    logic [INT_W-1:0] int_stat_ff; // sticky events
    logic [INT_W-1:0] nxt_int_stat;
    logic [INT_W-1:0] int_mask_ff; // enables
    logic [INT_W-1:0] nxt_int_mask;
    logic [INT_W-1:0] int_evt;
    logic [DATA_W-1:0] rdata_ff; // read answer
    logic [DATA_W-1:0] nxt_rdata;

    // write-one to the control register fires read-complete
    assign rdc_pulse = reg_wr && reg_addr == CTRL_ADDR
                       && reg_wdata[CTRL_RDC_BIT];
    // byte count write or marker advance both count a packet
    assign usb_inc = rx_byte_count_wr || advance_write_marker;

    // one index engine per endpoint
    for (genvar g = 0; g < N_EP; g++) begin : gen_ep
        rx_index_if ch_if ();
        // usb events go to the endpoint they name
        assign ch_if.inc = usb_inc && usb_ep == SEL_W'(g);
        // firmware events go to the selected endpoint
        assign ch_if.dec = rdc_pulse && endpoint_select == SEL_W'(g);
        assign ch_if.sof = usb_sof;
        assign ch_if.dual = ctrl_dual_ff;
        assign ep_idx[g] = ch_if.idx;
        assign ep_pkt_evt[g] = usb_sof && ch_if.pend != 2'h0;
        rx_index_engine u_engine (
            .clk(clk),
            .resetn(resetn),
            .clk_en(clk_en),
            .ch(ch_if)
        );
    end

    // selected endpoint view
    always_comb begin
        sel_idx = ep_idx[endpoint_select];
        // empty whenever no packet is visible
        sel_empty = (sel_idx == 2'b00);
    end

    // register next values: control, interrupts, read answer
    always_comb begin
        nxt_ctrl_dual = ctrl_dual_ff;
        nxt_int_mask = int_mask_ff;
        nxt_int_stat = int_stat_ff;
        nxt_rdata = RDATA_RST;
        // events: packet became visible, read-complete on empty
        int_evt = '0;
        int_evt[INT_PKT_BIT] = |ep_pkt_evt;
        int_evt[INT_UNDER_BIT] = rdc_pulse && sel_empty;
        if (reg_wr) begin
            unique case (reg_addr)
                CTRL_ADDR: begin
                    nxt_ctrl_dual = reg_wdata[CTRL_DUAL_BIT];
                end
                INT_STAT_ADDR: begin
                    // write one to clear
                    nxt_int_stat = int_stat_ff & ~reg_wdata[INT_W-1:0];
                end
                INT_MASK_ADDR: begin
                    nxt_int_mask = reg_wdata[INT_W-1:0];
                end
                // flag register is read-only
                default: begin
                end
            endcase
        end
        // set wins over a clear in the same cycle
        nxt_int_stat = nxt_int_stat | int_evt;
        if (reg_rd) begin
            unique case (reg_addr)
                FLAGS_ADDR: begin
                    // reserved and unbuilt flags read zero
                    nxt_rdata[IDX_HI:IDX_LO] = sel_idx;
                    nxt_rdata[EMPTY_BIT] = sel_empty;
                end
                CTRL_ADDR: begin
                    nxt_rdata[CTRL_DUAL_BIT] = ctrl_dual_ff;
                end
                INT_STAT_ADDR: begin
                    nxt_rdata[INT_W-1:0] = int_stat_ff;
                end
                INT_MASK_ADDR: begin
                    nxt_rdata[INT_W-1:0] = int_mask_ff;
                end
                // unmapped reads answer zero
                default: begin
                end
            endcase
        end
    end

    // register only
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_dual_ff <= CTRL_DUAL_RST;
            int_stat_ff <= INT_RST;
            int_mask_ff <= INT_RST;
            rdata_ff <= RDATA_RST;
        end else if (clk_en) begin
            ctrl_dual_ff <= nxt_ctrl_dual;
            int_stat_ff <= nxt_int_stat;
            int_mask_ff <= nxt_int_mask;
            rdata_ff <= nxt_rdata;
        end
    end

    // answer stands for one cycle, held longer while clk_en is low, flags always readable,
    // so firmware can check them around each fifo read
    assign reg_rdata = rdata_ff;
    // level interrupt while any unmasked event is pending
    assign irq = |(int_stat_ff & int_mask_ff);

    AST_READ_FLAGS: assert property (
        @(posedge clk) disable iff (!resetn)
        clk_en && reg_rd && reg_addr == FLAGS_ADDR
        |=> reg_rdata[IDX_HI:IDX_LO] == $past(sel_idx)
            && reg_rdata[5:4] == 2'b00)
        else $error("flag read shows wrong endpoint index");

    AST_EMPTY_LIVE: assert property (
        @(posedge clk) disable iff (!resetn)
        clk_en && reg_rd && reg_addr == FLAGS_ADDR
        |=> reg_rdata[EMPTY_BIT] == (reg_rdata[IDX_HI:IDX_LO] == 2'b00))
        else $error("empty flag disagrees with index");

    AST_RDC_NOW: assert property (
        @(posedge clk) disable iff (!resetn)
        clk_en && rdc_pulse && !usb_sof && sel_idx == 2'b01
        |=> ep_idx[$past(endpoint_select)] == 2'b00)
        else $error("read-complete not applied at once");

    AST_UNDER_IRQ: assert property (
        @(posedge clk) disable iff (!resetn)
        clk_en && rdc_pulse && sel_empty && int_mask_ff[INT_UNDER_BIT]
        |=> int_stat_ff[INT_UNDER_BIT] && irq)
        else $error("empty read-complete did not raise irq");

    // read answer stands one cycle, zero after every enabled cycle without a read
    AST_RDATA_IDLE: assert property (
        @(posedge clk) disable iff (!resetn)
        clk_en && !reg_rd |=> reg_rdata == RDATA_RST)
        else $error("read data not zero outside answer cycle");

    // low enable holds every register; reset edge kept out
    AST_FREEZE_HOLD: assert property (
        @(posedge clk) disable iff (!resetn)
        resetn && !clk_en |=> $stable(rdata_ff) && $stable(int_stat_ff)
            && $stable(ctrl_dual_ff) && $stable(int_mask_ff))
        else $error("state moved while clock enable low");

    // set wins over a write-one clear in the same cycle
    AST_SET_WINS: assert property (
        @(posedge clk) disable iff (!resetn)
        clk_en && (|ep_pkt_evt) |=> int_stat_ff[INT_PKT_BIT])
        else $error("packet event lost to status clear");

    // sticky: status only drops through a write-one clear
    AST_STAT_STICKY: assert property (
        @(posedge clk) disable iff (!resetn)
        clk_en && int_stat_ff[INT_PKT_BIT]
        && !(reg_wr && reg_addr == INT_STAT_ADDR)
        |=> int_stat_ff[INT_PKT_BIT])
        else $error("packet status dropped without a clear");

    // mask register takes exactly what firmware writes
    AST_MASK_WRITE: assert property (
        @(posedge clk) disable iff (!resetn)
        clk_en && reg_wr && reg_addr == INT_MASK_ADDR
        |=> int_mask_ff == $past(reg_wdata[INT_W-1:0]))
        else $error("mask register did not take written value");
endmodule // usb_rx_fifo_flag_status
`default_nettype wire

// File: design/usb_rx_flag_pkg.sv
/*
  constants, index type and index step functions shared by the
  receive fifo flag block and its per-endpoint index engine.
  assumes nothing beyond a systemverilog compiler.
*/
`default_nettype none
package usb_rx_flag_pkg;
    // sizes (module parameters default to these)
    localparam int NUM_EP = 4;
    localparam int EP_W = 2;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [7:0] FLAGS_ADDR = 8'hE5;
    localparam logic [7:0] CTRL_ADDR = 8'hF0;
    localparam logic [7:0] INT_STAT_ADDR = 8'hF1;
    localparam logic [7:0] INT_MASK_ADDR = 8'hF2;
    // field positions
    localparam int IDX_HI = 7;
    localparam int IDX_LO = 6;
    localparam int EMPTY_BIT = 3;
    localparam int CTRL_DUAL_BIT = 0;
    localparam int CTRL_RDC_BIT = 1;
    localparam int INT_PKT_BIT = 0;
    localparam int INT_UNDER_BIT = 1;
    localparam int INT_W = 2;
    // reset values
    localparam logic [7:0] FLAGS_RST = 8'h08;
    localparam logic [1:0] IDX_RST = 2'h0;
    localparam logic [1:0] PEND_RST = 2'h0;
    localparam logic CTRL_DUAL_RST = 1'b0;
    localparam logic [1:0] INT_RST = 2'h0;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // two-bit packet index
    typedef logic [1:0] pkt_idx_t;

    // one packet added: 00/01 -> 01, 10/11 -> 11 in dual mode
    function automatic pkt_idx_t step_up(input pkt_idx_t i,
                                         input logic dual);
        step_up = dual ? {i[1], 1'b1} : 2'b01;
    endfunction

    // one packet removed: 11 -> 01, anything else -> 00
    function automatic pkt_idx_t step_dn(input pkt_idx_t i);
        step_dn = (i == 2'b11) ? 2'b01 : 2'b00;
    endfunction
endpackage
`default_nettype wire

// File: design/rx_index_if.sv
/*
  link between the flag block and one per-endpoint index engine.
  assumes the package usb_rx_flag_pkg is compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
interface rx_index_if;
    import usb_rx_flag_pkg::*;
    logic inc; // usb side added a packet (pulse)
    logic dec; // firmware read-complete (pulse)
    logic sof; // start of frame (pulse)
    logic dual; // dual packet mode level
    pkt_idx_t idx; // visible packet index
    logic [1:0] pend; // usb increments waiting for sof
    modport engine (input inc, input dec, input sof, input dual,
                    output idx, output pend);
    modport ctrl (output inc, output dec, output sof, output dual,
                  input idx, input pend);
endinterface
`default_nettype wire

// File: design/rx_index_engine.sv
/*
  packet index engine for one endpoint's receive fifo.
  assumes single-cycle event pulses, all synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module rx_index_engine
    import usb_rx_flag_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // link to the flag block
    rx_index_if.engine ch
);
    pkt_idx_t idx_ff; // visible index
    pkt_idx_t nxt_idx;
    logic [1:0] pend_ff; // deferred usb increments
    logic [1:0] nxt_pend;

    // next index: deferred ups at sof, then immediate down
    always_comb begin
        nxt_idx = idx_ff;
        nxt_pend = pend_ff;
        if (ch.sof) begin
            // usb increments become visible only now
            if (pend_ff != 2'h0) begin
                nxt_idx = step_up(nxt_idx, ch.dual);
            end
            if (pend_ff == 2'h2) begin
                nxt_idx = step_up(nxt_idx, ch.dual);
            end
            nxt_pend = 2'h0;
        end
        if (ch.inc && nxt_pend != 2'h2) begin
            // saturate: at most two packets fit
            nxt_pend = nxt_pend + 2'h1;
        end
        if (ch.dec) begin
            nxt_idx = step_dn(nxt_idx);
        end
    end

    // register only; reset wins over the freeze
    always_ff @(posedge clk) begin
        if (!resetn) begin
            idx_ff <= IDX_RST;
            pend_ff <= PEND_RST;
        end else if (clk_en) begin
            idx_ff <= nxt_idx;
            pend_ff <= nxt_pend;
        end
    end

    assign ch.idx = idx_ff;
    assign ch.pend = pend_ff;

    AST_INC_WAITS_SOF: assert property (
        @(posedge clk) disable iff (!resetn)
        clk_en && ch.inc && !ch.sof && !ch.dec |=> idx_ff == $past(idx_ff))
        else $error("usb increment visible before sof");

    AST_SOF_APPLY: assert property (
        @(posedge clk) disable iff (!resetn)
        clk_en && ch.sof && ch.dual && pend_ff == 2'h1 && !ch.dec
        && idx_ff == 2'b10 |=> idx_ff == 2'b11)
        else $error("sof did not move 10 to 11");

    AST_DEC_TWO: assert property (
        @(posedge clk) disable iff (!resetn)
        clk_en && ch.dec && !ch.sof && idx_ff == 2'b11 |=> idx_ff == 2'b01)
        else $error("read-complete from 11 gave wrong index");

    AST_DEC_ONE: assert property (
        @(posedge clk) disable iff (!resetn)
        clk_en && ch.dec && !ch.sof && idx_ff != 2'b11 |=> idx_ff == 2'b00)
        else $error("read-complete did not clear index");

    AST_PEND_CLEAR: assert property (
        @(posedge clk) disable iff (!resetn)
        clk_en && ch.sof && !ch.inc |=> pend_ff == 2'h0)
        else $error("pending increments survived sof");
endmodule // rx_index_engine
`default_nettype wire

// File: testbench/usb_fiu_model.sv
/*
  usb function interface stand-in: packet count pulses and sof.
  assumes the bench calls its tasks from a single process.
*/
`timescale 1ns/100ps
`default_nettype none
module usb_fiu_model (
    // clock
    input wire logic clk,
    // usb side pulses
    output logic [1:0] usb_ep,
    output logic rx_byte_count_wr,
    output logic advance_write_marker,
    output logic usb_sof
);
    // quiet at time zero
    initial begin
        usb_ep = 2'h0;
        rx_byte_count_wr = 1'b0;
        advance_write_marker = 1'b0;
        usb_sof = 1'b0;
    end
    // one packet counted; ep inverted after so no stale value lingers
    task automatic add_pkt(input logic [1:0] ep, input logic mark);
        @(posedge clk);
        usb_ep <= ep;
        rx_byte_count_wr <= ~mark;
        advance_write_marker <= mark;
        @(posedge clk);
        rx_byte_count_wr <= 1'b0;
        advance_write_marker <= 1'b0;
        usb_ep <= ~ep;
    endtask
    // frame start publishes queued packets
    task automatic sof();
        @(posedge clk);
        usb_sof <= 1'b1;
        @(posedge clk);
        usb_sof <= 1'b0;
    endtask
endmodule // usb_fiu_model
`default_nettype wire

// File: testbench/usb_rx_fifo_flag_status_test.sv
/*
  self-checking bench for the receive fifo flag block.
  assumes the design package and the partner model are compiled.
*/
`timescale 1ns/100ps
`default_nettype none
module usb_rx_fifo_flag_status_test;
    import usb_rx_flag_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] endpoint_select = 2'h0;
    logic [7:0] reg_rdata;
    logic irq;
    logic [1:0] usb_ep;
    logic byte_wr, mark, sof;
    logic rd_d = 1'b0; // a read answer is due this cycle
    logic [7:0] exp_q[$]; // expected read data, oldest first
    int error_cnt = 0;
    int tests_run = 0;
    logic [1:0] ep;
    int n;

    always #2.5 clk = ~clk;

    usb_fiu_model fiu (.clk(clk), .usb_ep(usb_ep),
        .rx_byte_count_wr(byte_wr), .advance_write_marker(mark),
        .usb_sof(sof));
    usb_rx_fifo_flag_status dut (.clk(clk), .resetn(resetn),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .endpoint_select(endpoint_select), .usb_ep(usb_ep),
        .rx_byte_count_wr(byte_wr), .advance_write_marker(mark),
        .usb_sof(sof), .irq(irq));

    // comparison and tally
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // answer watcher: read data only stands the cycle after the strobe
    always @(posedge clk) begin
        if (rd_d && exp_q.size() > 0) begin
            check(reg_rdata, exp_q.pop_front());
        end
        rd_d <= reg_rd;
    end
    // single-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // single-cycle register read; expectation noted first
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    // verdict; also reached when a wait runs out
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        void'($urandom(32'h1e13d2fd));
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rd(FLAGS_ADDR, 8'h08);
        rd(CTRL_ADDR, 8'h00);
        rd(8'h10, 8'h00);
        wr(FLAGS_ADDR, 8'hCF);
        rd(FLAGS_ADDR, 8'h08);
        $display("test reset done");
        // single mode: count write, held until sof
        fiu.add_pkt(2'h0, 1'b0);
        rd(FLAGS_ADDR, 8'h08);
        fiu.sof();
        rd(FLAGS_ADDR, 8'h40);
        wr(CTRL_ADDR, 8'h02);
        rd(FLAGS_ADDR, 8'h08);
        wr(CTRL_ADDR, 8'h02);
        rd(FLAGS_ADDR, 8'h08);
        $display("test single done");
        // per-endpoint copies
        fiu.add_pkt(2'h1, 1'b1);
        fiu.sof();
        endpoint_select <= 2'h1;
        rd(FLAGS_ADDR, 8'h40);
        endpoint_select <= 2'h0;
        rd(FLAGS_ADDR, 8'h08);
        $display("test endpoint done");
        // dual mode, random endpoint and packet count
        wr(CTRL_ADDR, 8'h01);
        ep = 2'h2 + 2'($urandom % 2);
        n = 1 + int'($urandom % 2);
        endpoint_select <= ep;
        repeat (n) fiu.add_pkt(ep, 1'($urandom % 2));
        fiu.sof();
        rd(FLAGS_ADDR, 8'h40);
        wr(CTRL_ADDR, 8'h03);
        rd(FLAGS_ADDR, 8'h08);
        $display("test dual done");
        // interrupt: status set, mask, clear
        rd(INT_STAT_ADDR, 8'h03);
        #1 check({7'h00, irq}, 8'h00);
        wr(INT_MASK_ADDR, 8'h03);
        #1 check({7'h00, irq}, 8'h01);
        wr(INT_STAT_ADDR, 8'h03);
        #1 check({7'h00, irq}, 8'h00);
        rd(INT_STAT_ADDR, 8'h00);
        rd(INT_MASK_ADDR, 8'h03);
        // unmasked underflow: read-complete on an empty endpoint
        wr(CTRL_ADDR, 8'h02);
        #1 check({7'h00, irq}, 8'h01);
        rd(INT_STAT_ADDR, 8'h02);
        wr(INT_STAT_ADDR, 8'h02);
        #1 check({7'h00, irq}, 8'h00);
        $display("test interrupt done");
        // freeze: a sof seen while the enable is low is not taken
        fiu.add_pkt(2'h0, 1'b0);
        clk_en <= 1'b0;
        fiu.sof();
        clk_en <= 1'b1;
        endpoint_select <= 2'h0;
        rd(FLAGS_ADDR, 8'h08);
        fiu.sof();
        rd(FLAGS_ADDR, 8'h40);
        $display("test freeze done");
        // bounded drain of pending answers
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) begin
            @(posedge clk);
        end
        if (exp_q.size() > 0) begin
            error_cnt++;
            $display("wrong value at %0t: answers missing", $time);
        end
        end_sim();
    end
endmodule // usb_rx_fifo_flag_status_test
`default_nettype wire
